/* File: design/flash_cmd_pkg.sv */
/*
 * constants, types and state for the serial flash command engine.
 * assumes a 125 MHz system clock that oversamples the serial link.
 */
package flash_cmd_pkg;
   localparam int         CLK_PERIOD_NS = 8;
   localparam int         AW            = 17;
   localparam int         PAGE          = 256;
   localparam logic [3:0] OP_HI         = 4'h0;
   localparam logic [2:0] OP_WRITE_EN   = 3'h6;
   localparam logic [2:0] OP_WRDI       = 3'h4;
   localparam logic [2:0] OP_STATUS_RD  = 3'h5;
   localparam logic [2:0] OP_STATUS_WR  = 3'h1;
   localparam logic [2:0] OP_READ       = 3'h3;
   localparam logic [2:0] OP_PROG       = 3'h2;
   localparam int         SR_PIN_EN     = 7;
   localparam int         SR_BP_HI      = 3;
   localparam int         SR_BP_LO      = 2;
   localparam int         SR_WEN        = 1;
   localparam int         SR_BUSY       = 0;
   localparam logic [7:0] SR_BUSY_VAL   = 8'hFF;
   localparam logic [AW-1:0] MASK_LARGE = 17'h1FFFF;
   localparam logic [AW-1:0] MASK_SMALL = 17'h0FFFF;
   localparam logic [AW-1:0] QTR_BASE   = 17'h18000;
   localparam logic [AW-1:0] HALF_BASE  = 17'h10000;
   localparam logic [1:0] BP_NONE       = 2'h0;
   localparam logic [1:0] BP_QTR        = 2'h1;
   localparam logic [1:0] BP_HALF       = 2'h2;
   localparam logic [1:0] BP_ALL        = 2'h3;
   localparam logic [7:0] ERASED        = 8'hFF;

   typedef enum logic [2:0] {
      ph_cmd, ph_addr, ph_read, ph_sread, ph_sdata, ph_pdata, ph_ignore
   } phase_type;

   typedef enum logic [1:0] {bz_none, bz_prog, bz_status} busy_type;

   typedef struct packed {
      phase_type       phase;
      busy_type        busy;
      logic [19:0]     cnt;
      logic [7:0]      sh;
      logic [2:0]      bitcnt;
      logic [1:0]      bytecnt;
      logic [2:0]      op;
      logic [AW-1:0]   addr;
      logic [7:0]      out;
      logic            so;
      logic            oe;
      logic            wen;
      logic [1:0]      bp;
      logic            pin_en;
      logic [2:0]      sr_new;
      logic            armed;
      logic [PAGE-1:0] pvalid;
   } ctl_type;

   typedef struct packed {
      logic       sck;
      logic       cs_n;
      logic       si;
      logic       wp_n;
   } pins_type;
endpackage

/* File: design/flash_cmd.sv */
/*
 * serial flash command engine: status write with protection, array read
 * and page program. assumes link pins are asynchronous and that the link
 * clock is far slower than sys_clk (at least four system clocks per half).
 */
module flash_cmd
   import flash_cmd_pkg::*;
#(
   parameter bit LARGE_VARIANT  = 1'b1,
   parameter int PROG_TIME_NS   = 20000,
   parameter int STATUS_TIME_NS = 20000
) (
   input  wire logic sys_clk_i,
   input  wire logic rst_n_i,
   input  wire logic sck_i,
   input  wire logic cs_n_i,
   input  wire logic si_i,
   input  wire logic wp_n_i,
   output logic      so_o,
   output logic      so_oe_o,
   output logic      busy_o
);
   localparam int PROG_CYC   = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STATUS_CYC = (STATUS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [AW-1:0] AMASK = LARGE_VARIANT ? MASK_LARGE : MASK_SMALL;

   if (PROG_CYC < PAGE + 1 || PROG_CYC >= 2**20 || STATUS_CYC < 2 || STATUS_CYC >= 2**20)
   begin : g_bad_timing
      $error("flash_cmd: cycle times out of range");
   end

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   pins_type sync1;
   pins_type sync2;
   pins_type prev;

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync1 <= '{sck: 1'b0, cs_n: 1'b1, si: 1'b0, wp_n: 1'b1};
         sync2 <= '{sck: 1'b0, cs_n: 1'b1, si: 1'b0, wp_n: 1'b1};
         prev  <= '{sck: 1'b0, cs_n: 1'b1, si: 1'b0, wp_n: 1'b1};
      end else begin
         sync1 <= '{sck: sck_i, cs_n: cs_n_i, si: si_i, wp_n: wp_n_i};
         sync2 <= sync1;
         prev  <= sync2;
      end
   end

   logic sck_rise;
   logic sck_fall;
   logic cs_rise;
   logic sel;
   assign sck_rise = sync2.sck & ~prev.sck;
   assign sck_fall = ~sync2.sck & prev.sck;
   assign cs_rise  = sync2.cs_n & ~prev.cs_n;
   assign sel      = ~sync2.cs_n & ~prev.cs_n;

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   logic [7:0] mem  [2**AW];
   logic [7:0] pbuf [PAGE];

   // protection of one address against the current level
   function automatic logic locked(input logic [1:0] bp, input logic [AW-1:0] a);
      logic r;
      r = 1'b0;
      if (bp == BP_ALL)
         r = 1'b1;
      else if (LARGE_VARIANT && bp == BP_HALF)
         r = (a >= HALF_BASE);
      else if (LARGE_VARIANT && bp == BP_QTR)
         r = (a >= QTR_BASE);
      return r;
   endfunction

   // ----------------------------------------------------------------
   // command engine
   // ----------------------------------------------------------------
   ctl_type         ctl;
   ctl_type         next_ctl;
   logic            hw_prot;
   logic [7:0]      status_byte;
   logic [7:0]      rx;
   logic            byte_done;
   logic            start_prog;
   logic            start_sr;
   logic            buf_we;
   logic [7:0]      buf_idx;
   logic            mem_we;
   logic [AW-1:0]   mem_addr;

   assign hw_prot     = ctl.pin_en & ~sync2.wp_n;
   assign rx          = {ctl.sh[6:0], sync2.si};
   assign byte_done   = sel & sck_rise & (ctl.bitcnt == 3'h7);
   assign status_byte = (ctl.busy != bz_none) ? SR_BUSY_VAL
                      : {ctl.pin_en, 3'h0, ctl.bp, ctl.wen, 1'b0};
   // a write starts only on a byte boundary at select rising
   assign start_prog  = cs_rise & ctl.phase == ph_pdata & ctl.bitcnt == 3'h0
                      & ctl.armed & ctl.wen & !locked(ctl.bp, ctl.addr);
   assign start_sr    = cs_rise & ctl.phase == ph_sdata & ctl.bitcnt == 3'h0
                      & ctl.armed & ctl.wen & !hw_prot;
   assign buf_we      = byte_done & ctl.phase == ph_pdata;
   assign buf_idx     = ctl.addr[7:0];
   assign mem_addr    = {ctl.addr[AW-1:8], ctl.cnt[7:0]};
   assign mem_we      = ctl.busy == bz_prog & ctl.cnt < 20'(PAGE) & ctl.pvalid[ctl.cnt[7:0]];

   always_comb begin
      next_ctl = ctl;
      if (sck_fall && sel) begin
         next_ctl.so  = ctl.out[7];
         next_ctl.out = {ctl.out[6:0], 1'b0};
      end
      if (sel && sck_rise) begin
         next_ctl.sh     = rx;
         next_ctl.bitcnt = ctl.bitcnt + 3'h1;
      end
      if (byte_done) begin
         unique case (ctl.phase)
            ph_cmd: begin
               next_ctl.op      = rx[2:0];
               next_ctl.bytecnt = 2'h0;
               next_ctl.armed   = 1'b0;
               next_ctl.phase   = ph_ignore;
               if (rx[7:4] == OP_HI && rx[2:0] == OP_STATUS_RD) begin
                  next_ctl.phase = ph_sread;
                  next_ctl.out   = status_byte;
               end else if (rx[7:4] == OP_HI && ctl.busy == bz_none) begin
                  unique case (rx[2:0])
                     OP_WRITE_EN: next_ctl.wen = 1'b1;
                     OP_WRDI: next_ctl.wen = 1'b0;
                     OP_STATUS_WR: next_ctl.phase = ctl.wen ? ph_sdata : ph_ignore;
                     OP_READ: next_ctl.phase = ph_addr;
                     OP_PROG: next_ctl.phase = ctl.wen ? ph_addr : ph_ignore;
                     default: next_ctl.phase = ph_ignore;
                  endcase
               end
            end
            ph_addr: begin
               next_ctl.addr    = {ctl.addr[AW-9:0], rx} & AMASK;
               next_ctl.bytecnt = ctl.bytecnt + 2'h1;
               if (ctl.bytecnt == 2'h2) begin
                  if (ctl.op == OP_READ) begin
                     next_ctl.phase = ph_read;
                     next_ctl.out   = mem[{ctl.addr[AW-9:0], rx} & AMASK];
                     next_ctl.addr  = ({ctl.addr[AW-9:0], rx} + 17'h1) & AMASK;
                  end else begin
                     next_ctl.phase  = ph_pdata;
                     next_ctl.pvalid = '0;
                  end
               end
            end
            ph_read: begin
               next_ctl.out  = mem[ctl.addr];
               next_ctl.addr = (ctl.addr + 17'h1) & AMASK;
            end
            ph_sread: next_ctl.out = status_byte;
            ph_sdata: begin
               next_ctl.sr_new = {rx[SR_PIN_EN], rx[SR_BP_HI], rx[SR_BP_LO]};
               next_ctl.armed  = 1'b1;
            end
            ph_pdata: begin
               next_ctl.pvalid[buf_idx] = 1'b1;
               next_ctl.addr  = {ctl.addr[AW-1:8], buf_idx + 8'h1};
               next_ctl.armed = 1'b1;
            end
            ph_ignore: next_ctl.phase = ph_ignore;
         endcase
      end
      next_ctl.oe = sel & (next_ctl.phase == ph_read | next_ctl.phase == ph_sread);
      if (start_prog) begin
         next_ctl.busy = bz_prog;
         next_ctl.cnt  = 20'(PROG_CYC - 1);
      end
      if (start_sr) begin
         next_ctl.busy = bz_status;
         next_ctl.cnt  = 20'(STATUS_CYC - 1);
      end
      if (ctl.busy != bz_none) begin
         next_ctl.cnt = ctl.cnt - 20'h1;
         if (ctl.cnt == 20'h0) begin
            next_ctl.busy = bz_none;
            next_ctl.wen  = 1'b0;
            if (ctl.busy == bz_status)
               {next_ctl.pin_en, next_ctl.bp} = ctl.sr_new;
         end
      end
      // select high ends any frame and clears partial bits
      if (sync2.cs_n) begin
         next_ctl.phase  = ph_cmd;
         next_ctl.bitcnt = 3'h0;
         next_ctl.oe     = 1'b0;
      end
   end

   // the protect bits model nonvolatile cells; they reset to unprotected
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i)
         ctl <= '{phase: ph_cmd, busy: bz_none, default: '0};
      else
         ctl <= next_ctl;
   end

   // array and page buffer carry no reset, like the real cells
   always_ff @(posedge sys_clk_i) begin
      if (buf_we)
         pbuf[buf_idx] <= rx;
      if (mem_we)
         mem[mem_addr] <= mem[mem_addr] & pbuf[ctl.cnt[7:0]];
   end

   initial begin
      for (int i = 0; i < 2**AW; i++)
         mem[i] = ERASED;
   end

   assign so_o    = ctl.so;
   assign so_oe_o = ctl.oe;
   assign busy_o  = ctl.busy != bz_none;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);

   a_sr_hw_refuse: assert property (start_sr |-> !(ctl.pin_en && !sync2.wp_n))
      else $error("status write started under hardware protection");
   a_pin_en_held: assert property (ctl.pin_en && !sync2.wp_n && ctl.busy == bz_none ##1
      sync2.wp_n == 1'b0 |-> ctl.pin_en)
      else $error("pin enable cleared while pin low");
   a_prog_locked: assert property (start_prog |-> !locked(ctl.bp, ctl.addr))
      else $error("program started in locked range");
   a_write_needs_wen: assert property (start_prog || start_sr |-> ctl.wen)
      else $error("write started without write enable");
   a_busy_ignores: assert property (ctl.busy != bz_none |=> !$rose(ctl.wen))
      else $error("command honoured during write cycle");
   a_wen_clear_end: assert property ($fell(busy_o) |-> !ctl.wen)
      else $error("write enable survived write cycle");
   a_busy_status: assert property (busy_o |-> status_byte[SR_BUSY] == 1'b1)
      else $error("busy bit low during write cycle");
   a_prog_len: assert property (start_prog |=> busy_o [*8])
      else $error("program cycle too short");
   a_read_incr: assert property (byte_done && ctl.phase == ph_read |=>
      ctl.addr == (($past(ctl.addr) + 17'h1) & AMASK))
      else $error("read address not incremented");
   a_addr_width: assert property ((ctl.addr & ~AMASK) == '0)
      else $error("address bits beyond variant width");
   a_so_on_fall: assert property ($changed(ctl.so) |-> $past(sck_fall))
      else $error("serial output moved off a falling clock");

   // ----------------------------------------------------------------
   // write cycle, protection and link checks
   // ----------------------------------------------------------------
   a_sr_bits_end: assert property (
      ctl.busy == bz_status && ctl.cnt == 20'h0 |=> {ctl.pin_en, ctl.bp} == $past(ctl.sr_new))
      else $error("status bits not taken at end of cycle");
   a_bits_hold: assert property (
      ctl.busy != bz_status || ctl.cnt != 20'h0 |=> $stable({ctl.pin_en, ctl.bp}))
      else $error("status bits moved outside a status cycle end");
   a_sr_start_busy: assert property (
      start_sr |=> ctl.busy == bz_status)
      else $error("status write did not start its cycle");
   a_sr_wen_clear: assert property (
      ctl.busy == bz_status && ctl.cnt == 20'h0 |=> !ctl.wen)
      else $error("write enable survived status cycle");
   a_prog_start_busy: assert property (
      start_prog |=> ctl.busy == bz_prog)
      else $error("program did not start its cycle");
   a_prog_wen_clear: assert property (
      ctl.busy == bz_prog && ctl.cnt == 20'h0 |=> !ctl.wen)
      else $error("write enable survived program cycle");
   a_hw_blocks_sr: assert property (
      hw_prot && ctl.busy == bz_none |=> ctl.busy != bz_status)
      else $error("status cycle began under hardware protection");
   a_busy_cmd_drop: assert property (
      busy_o && byte_done && ctl.phase == ph_cmd |=> ctl.phase inside {ph_sread, ph_ignore})
      else $error("command honoured while busy");
   a_busy_status_rd: assert property (
      busy_o && byte_done && ctl.phase == ph_cmd && rx[7:4] == OP_HI
      && rx[2:0] == OP_STATUS_RD |=> ctl.phase == ph_sread)
      else $error("status read refused while busy");
   a_no_wen_drop: assert property (
      byte_done && ctl.phase == ph_cmd && !busy_o && !ctl.wen && rx[7:4] == OP_HI
      && (rx[2:0] == OP_PROG || rx[2:0] == OP_STATUS_WR) |=> ctl.phase == ph_ignore)
      else $error("write command accepted without write enable");
   a_page_stays: assert property (
      byte_done && ctl.phase == ph_pdata |=> $stable(ctl.addr[AW-1:8]))
      else $error("program address left its page");
   a_pvalid_mark: assert property (
      buf_we |=> ctl.pvalid[$past(buf_idx)])
      else $error("buffered byte not marked for programming");
   a_oe_drop: assert property (
      sync2.cs_n |=> !so_oe_o)
      else $error("output enable held after deselect");
   a_oe_phase: assert property (
      so_oe_o |-> ctl.phase == ph_read || ctl.phase == ph_sread)
      else $error("output enabled outside a read phase");
   a_rd_wrap: assert property (
      byte_done && ctl.phase == ph_read && ctl.addr == AMASK |=> ctl.addr == '0)
      else $error("read address did not wrap to zero");
   a_idle_bits_zero: assert property (
      !busy_o |-> status_byte[SR_PIN_EN-1:SR_BP_HI+1] == '0)
      else $error("unused status bits set while idle");
endmodule

/* File: dv/spi_master_model.sv */
/*
 * serial master model for the flash command engine: frames, bytes, mode 0/3.
 * assumes the bench calls its tasks in sequence and that sys_clk runs freely.
 */
module spi_master_model (
   input  wire logic sys_clk_i,
   input  wire logic so_i,
   input  wire logic so_oe_i,
   output logic      sck_o,
   output logic      cs_n_o,
   output logic      si_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   int         half    = 8;
   bit         mode3   = 1'b0;
   logic       oe_seen = 1'b0;
   logic [7:0] rx      = 8'h00;
   initial begin
      sck_o  = 1'b0;
      cs_n_o = 1'b1;
      si_o   = 1'b0;
   end
   // ---------------------------------------------------------------
   // link tasks
   // ---------------------------------------------------------------
   // the enable is watched here so that only the caller's process writes it
   task automatic wait_clk(input int n);
      repeat (n) begin
         @(posedge sys_clk_i);
         if (so_oe_i === 1'b1) begin
            oe_seen = 1'b1;
         end
      end
   endtask
   task automatic start();
      @(posedge sys_clk_i);
      sck_o   <= mode3;
      cs_n_o  <= 1'b0;
      oe_seen = 1'b0;
      wait_clk(half);
   endtask
   // msb first, drive on fall, device samples on rise
   task automatic byte_x(input logic [7:0] tx);
      for (int i = 7; i >= 0; i--) begin
         sck_o <= 1'b0;
         si_o  <= tx[i];
         wait_clk(half);
         sck_o <= 1'b1;
         rx[i] = so_i;
         wait_clk(half);
      end
   endtask
   // select rises in the clock-low time after the last bit
   task automatic stop();
      sck_o <= 1'b0;
      wait_clk(half);
      cs_n_o <= 1'b1;
      si_o   <= ~si_o; // released line must not look like held data
      wait_clk(4);
      sck_o <= mode3;
      wait_clk(6);
   endtask
endmodule

/* File: dv/tb_spi_flash_protect_read_program.sv */
/*
 * self-checking bench for flash_cmd: read, program, status write, protection.
 * assumes the large variant and shortened self-timed cycles.
 */
module tb_spi_flash_protect_read_program
   import flash_cmd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic       sys_clk = 1'b0;
   logic       rst_n   = 1'b0;
   logic       wp_n    = 1'b1;
   logic       sck;
   logic       cs_n;
   logic       si;
   logic       so;
   logic       so_oe;
   logic       busy;
   int         bad_count    = 0;
   int         total_checks = 0;
   logic [7:0] v;
   logic [7:0] q[$];
   always #4 sys_clk = ~sys_clk;
   flash_cmd #(
      .PROG_TIME_NS   (12000),
      .STATUS_TIME_NS (12000)
   ) DUT (
      .sys_clk_i (sys_clk),
      .rst_n_i   (rst_n),
      .sck_i     (sck),
      .cs_n_i    (cs_n),
      .si_i      (si),
      .wp_n_i    (wp_n),
      .so_o      (so),
      .so_oe_o   (so_oe),
      .busy_o    (busy)
   );
   spi_master_model m (
      .sys_clk_i (sys_clk),
      .so_i      (so),
      .so_oe_i   (so_oe),
      .sck_o     (sck),
      .cs_n_o    (cs_n),
      .si_o      (si)
   );
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("checks=%0d mismatches=%0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic cmd(input logic [7:0] op);
      m.start();
      m.byte_x(op);
      m.stop();
   endtask
   task automatic head(input logic [7:0] op, input logic [23:0] a);
      m.start();
      m.byte_x(op);
      m.byte_x(a[23:16]);
      m.byte_x(a[15:8]);
      m.byte_x(a[7:0]);
   endtask
   task automatic status(output logic [7:0] s);
      m.start();
      m.byte_x(8'h05);
      m.byte_x(8'h00);
      s = m.rx;
      m.stop();
   endtask
   task automatic rd(input logic [7:0] op, input logic [23:0] a, input logic [7:0] e[$]);
      head(op, a);
      foreach (e[i]) begin
         m.byte_x(8'h00);
         check(m.rx, e[i]);
      end
      check(m.oe_seen, 8'h01);
      m.stop();
   endtask
   task automatic prog(input bit en, input logic [23:0] a, input logic [7:0] d[$]);
      if (en) cmd(8'h06);
      head(8'h02, a);
      foreach (d[i]) m.byte_x(d[i]);
      m.stop();
   endtask
   task automatic status_write_cmd(input logic [7:0] d);
      cmd(8'h0E);
      m.start();
      m.byte_x(8'h01);
      m.byte_x(d);
      m.stop();
   endtask
   task automatic settle();
      int n = 0;
      while (busy !== 1'b0 && n < 5000) begin
         @(posedge sys_clk);
         n++;
      end
      check(busy, 8'h00);
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset_nowen();
      status(v);
      check(v, 8'h00);
      prog(0, 24'h000010, '{8'h12});
      check(busy, 8'h00);
      rd(8'h03, 24'h000010, '{8'hFF});
   endtask
   task automatic t_program();
      cmd(8'h0E);
      status(v);
      check(v, 8'h02);
      prog(1, 24'h8E00FE, '{8'hA5, 8'h5A, 8'h3C});
      check(busy, 8'h01);
      status(v);
      check(v, SR_BUSY_VAL);
      head(8'h03, 24'h000000);
      m.byte_x(8'h00);
      check(m.oe_seen, 8'h00);
      m.stop();
      settle();
      status(v);
      check(v, 8'h00);
      rd(8'h03, 24'h0000FE, '{8'hA5, 8'h5A});
      rd(8'h03, 24'h000000, '{8'h3C, 8'hFF});
   endtask
   task automatic t_overflow();
      q = {};
      for (int i = 0; i < 256; i++) q.push_back(8'hF0);
      q.push_back(8'h0F);
      prog(1, 24'h000200, q);
      settle();
      rd(8'h03, 24'h000200, '{8'h0F, 8'hF0});
   endtask
   task automatic t_protect();
      status_write_cmd(8'h8C);
      check(busy, 8'h01);
      settle();
      status(v);
      check(v, 8'h8C);
      @(posedge sys_clk);
      wp_n <= 1'b0;
      status_write_cmd(8'h00);
      check(busy, 8'h00);
      status(v);
      check(v, 8'h8E);
      prog(1, 24'h000300, '{8'h11});
      check(busy, 8'h00);
      rd(8'h03, 24'h000300, '{8'hFF});
      @(posedge sys_clk);
      wp_n <= 1'b1;
      status_write_cmd(8'h04);
      settle();
      status(v);
      check(v, 8'h04);
      prog(1, 24'h018000, '{8'h22});
      check(busy, 8'h00);
      prog(1, 24'h017FFF, '{8'h33});
      settle();
      rd(8'h03, 24'h017FFF, '{8'h33, 8'hFF});
   endtask
   task automatic t_disable();
      cmd(8'h06);
      cmd(8'h0C);
      status(v);
      check(v, 8'h00);
      prog(0, 24'h000400, '{8'h44});
      check(busy, 8'h00);
      rd(8'h03, 24'h000400, '{8'hFF});
   endtask
   // mode 3 with a slower master, read across the top of the array
   task automatic t_mode3_wrap();
      m.mode3 = 1'b1;
      m.half  = 12;
      rd(8'h0B, 24'h01FFFF, '{8'hFF, 8'h3C});
      m.mode3 = 1'b0;
      m.half  = 8;
   endtask
   initial begin
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      t_reset_nowen();
      t_disable();
      t_program();
      t_overflow();
      t_protect();
      t_mode3_wrap();
      end_sim();
   end
   // about one and a half times the expected run, inside the cycle budget
   initial begin
      #700us;
      bad_count++;
      end_sim();
   end
endmodule
